//--- rtl/lcs_sequencer.sv
`timescale 1ns/10ps
module lcs_sequencer (
  // Clock and reset
  input  wire logic              CLOCK_IN,
  input  wire logic              RESET_N_IN,
  // Comparator results and voltage select
  input  wire lcs_pkg::lcs_cmp_t CMP_IN,
  input  wire logic              VOLTAGE_SELECT_IN,
  // AXI4-Lite write address, data and response
  input  wire logic [7:0]        AWADDR_IN,
  input  wire logic              AWVALID_IN,
  output logic                   AWREADY_OUT,
  input  wire logic [31:0]       WDATA_IN,
  input  wire logic [3:0]        WSTRB_IN,
  input  wire logic              WVALID_IN,
  output logic                   WREADY_OUT,
  output logic [1:0]             BRESP_OUT,
  output logic                   BVALID_OUT,
  input  wire logic              BREADY_IN,
  // AXI4-Lite read
  input  wire logic [7:0]        ARADDR_IN,
  input  wire logic              ARVALID_IN,
  output logic                   ARREADY_OUT,
  output logic [31:0]            RDATA_OUT,
  output logic [1:0]             RRESP_OUT,
  output logic                   RVALID_OUT,
  input  wire logic              RREADY_IN,
  // Charger drive and status pins
  output lcs_pkg::lcs_drive_t    DRIVE_OUT,
  output logic                   CHARGE_INDICATOR_OUT,
  output logic                   CHARGE_INDICATOR_OE_OUT,
  output logic                   FAULT_INDICATOR_OUT,
  output logic                   FAULT_INDICATOR_OE_OUT,
  output logic                   POWER_DOWN_OUT
);

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  localparam int NCMP = $bits(lcs_pkg::lcs_cmp_t);
  logic [NCMP-1:0] meta_q;
  logic [NCMP-1:0] sync_q;
  logic            vsel_meta_q;
  logic            vsel_q;
  lcs_pkg::lcs_cmp_t c;
  assign c = lcs_pkg::lcs_cmp_t'(sync_q);

  // Two flops per comparator bit; the first is read only by the second.
  genvar gi;
  generate
    for (gi = 0; gi < NCMP; gi++) begin : g_sync
      always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
          meta_q[gi] <= 1'b0;
          sync_q[gi] <= 1'b0;
        end else begin
          meta_q[gi] <= CMP_IN[gi];
          sync_q[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

  // Voltage select follows the same two-flop path.
  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      vsel_meta_q <= 1'b0;
      vsel_q      <= 1'b0;
    end else begin
      vsel_meta_q <= VOLTAGE_SELECT_IN;
      vsel_q      <= vsel_meta_q;
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [31:0] ctrl_q;
  logic [31:0] tick_div_q;
  logic [3:0]  throt_q;
  logic [31:0] status_w;
  logic        aw_hold_q;
  logic        w_hold_q;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        do_write;

  // Address and data may arrive in either order; each is held until both.
  assign do_write = aw_hold_q && w_hold_q && !BVALID_OUT;

  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      aw_hold_q   <= 1'b0;
      w_hold_q    <= 1'b0;
      aw_addr_q   <= 8'h00;
      w_data_q    <= 32'h0000_0000;
      w_strb_q    <= 4'h0;
      AWREADY_OUT <= 1'b0;
      WREADY_OUT  <= 1'b0;
      BVALID_OUT  <= 1'b0;
      BRESP_OUT   <= 2'b00;
    end else begin
      AWREADY_OUT <= !aw_hold_q && !AWREADY_OUT && AWVALID_IN;
      WREADY_OUT  <= !w_hold_q && !WREADY_OUT && WVALID_IN;
      if (AWVALID_IN && AWREADY_OUT) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= AWADDR_IN;
      end
      if (WVALID_IN && WREADY_OUT) begin
        w_hold_q <= 1'b1;
        w_data_q <= WDATA_IN;
        w_strb_q <= WSTRB_IN;
      end
      if (do_write) begin
        aw_hold_q  <= 1'b0;
        w_hold_q   <= 1'b0;
        BVALID_OUT <= 1'b1;
        BRESP_OUT  <= (aw_addr_q == lcs_pkg::CTRL_OFFSET ||
                       aw_addr_q == lcs_pkg::TICK_OFFSET ||
                       aw_addr_q == lcs_pkg::THROT_OFFSET ||
                       aw_addr_q == lcs_pkg::STATUS_OFFSET)
                      ? 2'b00 : 2'b10;
      end else if (BVALID_OUT && BREADY_IN) begin
        BVALID_OUT <= 1'b0;
      end
    end
  end

  // Byte-enabled register updates.
  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      ctrl_q     <= lcs_pkg::CTRL_RESET;
      tick_div_q <= lcs_pkg::TICK_RESET;
      throt_q    <= lcs_pkg::THROT_RESET;
    end else if (do_write) begin
      for (int b = 0; b < 4; b++) begin
        if (w_strb_q[b]) begin
          if (aw_addr_q == lcs_pkg::CTRL_OFFSET)
            ctrl_q[b*8 +: 8] <= w_data_q[b*8 +: 8];
          if (aw_addr_q == lcs_pkg::TICK_OFFSET)
            tick_div_q[b*8 +: 8] <= w_data_q[b*8 +: 8];
        end
      end
      if (aw_addr_q == lcs_pkg::THROT_OFFSET && w_strb_q[0])
        throt_q <= w_data_q[3:0];
    end
  end

  // Reads answer one cycle after the address is taken.
  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      ARREADY_OUT <= 1'b0;
      RVALID_OUT  <= 1'b0;
      RDATA_OUT   <= 32'h0000_0000;
      RRESP_OUT   <= 2'b00;
    end else begin
      ARREADY_OUT <= ARVALID_IN && !ARREADY_OUT && !RVALID_OUT;
      if (ARVALID_IN && ARREADY_OUT) begin
        RVALID_OUT <= 1'b1;
        RRESP_OUT  <= 2'b00;
        unique case (ARADDR_IN)
          lcs_pkg::CTRL_OFFSET:   RDATA_OUT <= ctrl_q;
          lcs_pkg::STATUS_OFFSET: RDATA_OUT <= status_w;
          lcs_pkg::TICK_OFFSET:   RDATA_OUT <= tick_div_q;
          lcs_pkg::THROT_OFFSET:  RDATA_OUT <= {28'h0000000, throt_q};
          default: begin
            RDATA_OUT <= 32'h0000_0000;
            RRESP_OUT <= 2'b10;
          end
        endcase
      end else if (RVALID_OUT && RREADY_IN) begin
        RVALID_OUT <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Qualification
  // ----------------------------------------------------------------------
  logic [7:0] drop_cnt_q;
  logic       supply_ok_q;
  logic       temp_ok;
  logic       qualified;
  logic       enable_d1_q;

  // A supply drop counts only once it persists a full period.
  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      drop_cnt_q  <= 8'h00;
      supply_ok_q <= 1'b0;
    end else if (c.supply_ok) begin
      drop_cnt_q  <= 8'h00;
      supply_ok_q <= 1'b1;
    end else if (drop_cnt_q >= 8'(lcs_pkg::LOCKOUT_PERSIST_CYC - 1)) begin
      supply_ok_q <= 1'b0;
    end else begin
      drop_cnt_q <= drop_cnt_q + 8'h01;
    end
  end

  // Window compare, bypassed by the disable level or by software.
  assign temp_ok = c.temp_disable || !ctrl_q[lcs_pkg::CTRL_SENSE_EN_BIT] ||
                   (c.temp_low_ok && c.temp_high_ok);
  assign qualified = supply_ok_q && c.enable && temp_ok;

  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) enable_d1_q <= 1'b0;
    else             enable_d1_q <= c.enable;
  end

  // ----------------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------------
  logic [31:0] pre_q;
  logic [3:0]  throt_cnt_q;
  logic        base_tick;
  logic        tick;
  logic [15:0] hh_cnt_q;
  logic        hh_tick;
  logic [3:0]  t_pre_q;
  logic [3:0]  t_fast_q;
  logic [3:0]  t_term_q;
  logic        die_hold_q;
  lcs_pkg::lcs_state_t state_q;
  lcs_pkg::lcs_state_t state_d;

  assign base_tick = (pre_q == 32'h0000_0000);
  // Throttled tick gives only one of every throt_q ticks while regulating.
  assign tick = base_tick &&
                (!c.thermal_reg || throt_cnt_q == 4'h0);

  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      pre_q       <= 32'h0000_0000;
      throt_cnt_q <= 4'h0;
    end else begin
      pre_q <= base_tick ? tick_div_q : pre_q - 32'h0000_0001;
      if (base_tick)
        throt_cnt_q <= (throt_cnt_q == 4'h0) ? throt_q - 4'h1
                                               : throt_cnt_q - 4'h1;
    end
  end

  // Half-hour units keep the 1 : 1.5 : 3 ratio for any tick setting.
  assign hh_tick = tick && (hh_cnt_q == lcs_pkg::HALF_HOUR_TICKS - 16'h1);
  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      hh_cnt_q <= 16'h0000;
    end else if (state_q != state_d) begin
      hh_cnt_q <= 16'h0000;
    end else if (tick && !die_hold_q) begin
      hh_cnt_q <= hh_tick ? 16'h0000 : hh_cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      t_pre_q  <= 4'h0;
      t_fast_q <= 4'h0;
      t_term_q <= 4'h0;
    end else begin
      if (state_q != lcs_pkg::ST_TRICK) t_pre_q <= 4'h0;
      else if (hh_tick && !die_hold_q) t_pre_q <= t_pre_q + 4'h1;
      if (state_q != lcs_pkg::ST_FAST) t_fast_q <= 4'h0;
      else if (hh_tick && !die_hold_q) t_fast_q <= t_fast_q + 4'h1;
      if (state_q != lcs_pkg::ST_FAST && state_q != lcs_pkg::ST_CV)
        t_term_q <= 4'h0;
      else if (hh_tick && !die_hold_q) t_term_q <= t_term_q + 4'h1;
    end
  end

  // Die overheat holds charge until the cool comparator trips.
  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN)     die_hold_q <= 1'b0;
    else if (c.die_hot)  die_hold_q <= 1'b1;
    else if (c.die_cool) die_hold_q <= 1'b0;
  end

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      lcs_pkg::ST_IDLE:
        if (qualified)
          state_d = c.above_trickle ? lcs_pkg::ST_FAST
                                    : lcs_pkg::ST_TRICK;
      lcs_pkg::ST_TRICK:
        if (t_pre_q >= 4'(lcs_pkg::PRE_HALF_HOURS))
          state_d = lcs_pkg::ST_FAULT;
        else if (c.above_trickle)
          state_d = lcs_pkg::ST_FAST;
      lcs_pkg::ST_FAST:
        if (t_fast_q >= 4'(lcs_pkg::FAST_HALF_HOURS))
          state_d = lcs_pkg::ST_FAULT;
        else if (c.at_target)
          state_d = lcs_pkg::ST_CV;
      lcs_pkg::ST_CV:
        if (c.below_term_current ||
            t_term_q >= 4'(lcs_pkg::TERM_HALF_HOURS))
          state_d = lcs_pkg::ST_DONE;
      lcs_pkg::ST_DONE:
        if (qualified && c.below_restart)
          state_d = lcs_pkg::ST_IDLE;
      lcs_pkg::ST_FAULT:
        state_d = lcs_pkg::ST_FAULT;
    endcase
    // Loss of supply or enable ends the cycle and clears faults.
    if (!supply_ok_q || !c.enable)
      state_d = lcs_pkg::ST_IDLE;
  end

  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) state_q <= lcs_pkg::ST_IDLE;
    else             state_q <= state_d;
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  logic [15:0] flash_cnt_q;
  logic        flash_q;
  logic        charging;
  logic        running;

  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      flash_cnt_q <= 16'h0000;
      flash_q     <= 1'b0;
    end else if (base_tick) begin
      if (flash_cnt_q == lcs_pkg::FLASH_HALF_TICKS - 16'h1) begin
        flash_cnt_q <= 16'h0000;
        flash_q     <= !flash_q;
      end else begin
        flash_cnt_q <= flash_cnt_q + 16'h0001;
      end
    end
  end

  // A cycle only pauses for temperature or die heat, never ends.
  assign running  = state_q == lcs_pkg::ST_TRICK ||
                    state_q == lcs_pkg::ST_FAST || state_q == lcs_pkg::ST_CV;
  assign charging = running && temp_ok && !die_hold_q;
  assign status_w = {20'h00000, 4'(drop_cnt_q[3:0]), supply_ok_q, temp_ok,
                     state_q};

  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      DRIVE_OUT               <= '0;
      CHARGE_INDICATOR_OUT    <= 1'b0;
      CHARGE_INDICATOR_OE_OUT <= 1'b0;
      FAULT_INDICATOR_OUT     <= 1'b0;
      FAULT_INDICATOR_OE_OUT  <= 1'b0;
      POWER_DOWN_OUT          <= 1'b1;
    end else begin
      DRIVE_OUT.charge_en     <= charging;
      DRIVE_OUT.trickle       <= state_q == lcs_pkg::ST_TRICK;
      DRIVE_OUT.const_voltage <= state_q == lcs_pkg::ST_CV;
      DRIVE_OUT.target_42     <= vsel_q;
      CHARGE_INDICATOR_OUT    <= 1'b0;
      CHARGE_INDICATOR_OE_OUT <= (running && temp_ok) ||
        (state_q == lcs_pkg::ST_DONE && flash_q);
      FAULT_INDICATOR_OUT     <= 1'b0;
      FAULT_INDICATOR_OE_OUT  <= state_q == lcs_pkg::ST_FAULT ||
        (running && !temp_ok && flash_q);
      POWER_DOWN_OUT          <= !supply_ok_q;
    end
  end

endmodule : lcs_sequencer

//--- rtl/lcs_pkg.sv
package lcs_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] CTRL_OFFSET   = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] TICK_OFFSET   = 8'h08;
  localparam logic [7:0] THROT_OFFSET  = 8'h0c;

  // Control register fields.
  localparam int CTRL_SENSE_EN_BIT = 0;
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0001;
  // Base tick divider: cycles per timer tick, minus one.
  localparam logic [31:0] TICK_RESET  = 32'h0000_0014;
  // Throttle divider applied while thermal regulation is active.
  localparam logic [3:0]  THROT_RESET = 4'h2;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ           = 20_000_000;
  localparam int CLK_NS           = 50;
  // Nominal timer periods in half-hour ticks units (1.0 : 1.5 : 3.0 hours).
  localparam int PRE_HALF_HOURS   = 2;
  localparam int FAST_HALF_HOURS  = 3;
  localparam int TERM_HALF_HOURS  = 6;
  // Throttled timer ticks making up one half hour (base ticks unless regulating).
  localparam logic [15:0] HALF_HOUR_TICKS = 16'h0708;
  // Lockout drop must persist 1000 ns, i.e. 20 clock periods.
  localparam int LOCKOUT_PERSIST_NS = 1000;
  localparam int LOCKOUT_PERSIST_CYC =
    (LOCKOUT_PERSIST_NS + CLK_NS - 1) / CLK_NS;
  // Flash half period in base ticks (1 s nominal).
  localparam logic [15:0] FLASH_HALF_TICKS = 16'h0001;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_TRICK = 6'b000010,
    ST_FAST  = 6'b000100,
    ST_CV    = 6'b001000,
    ST_DONE  = 6'b010000,
    ST_FAULT = 6'b100000
  } lcs_state_t;

  typedef struct packed {
    logic supply_ok;
    logic enable;
    logic temp_low_ok;
    logic temp_high_ok;
    logic temp_disable;
    logic above_trickle;
    logic at_target;
    logic below_restart;
    logic below_term_current;
    logic die_hot;
    logic die_cool;
    logic thermal_reg;
  } lcs_cmp_t;

  typedef struct packed {
    logic charge_en;
    logic trickle;
    logic const_voltage;
    logic target_42;
  } lcs_drive_t;

endpackage : lcs_pkg

//--- test/lcs_sequencer_props.sv
`timescale 1ns/10ps
// Pin checker: ties drive and status outputs to held comparator levels.
module lcs_sequencer_props (
  // Clock and reset
  input wire logic                CLOCK_IN,
  input wire logic                RESET_N_IN,
  // Watched inputs
  input wire lcs_pkg::lcs_cmp_t   CMP_IN,
  input wire logic                VOLTAGE_SELECT_IN,
  // Watched outputs
  input wire lcs_pkg::lcs_drive_t DRIVE_OUT,
  input wire logic                CHARGE_INDICATOR_OE_OUT,
  input wire logic                FAULT_INDICATOR_OE_OUT,
  input wire logic                POWER_DOWN_OUT
);
  logic [7:0] bad_q, off_q, trk_q, tgt_q, sel_q;
  logic       sel_p_q;
  logic       qual_bad;

  function automatic logic [7:0] inc(input logic [7:0] v);
    return (v == 8'hff) ? v : v + 8'h01;
  endfunction : inc

  // Temperature only counts as bad while the disable level is low.
  assign qual_bad = !CMP_IN.enable || CMP_IN.die_hot ||
    (!(CMP_IN.temp_low_ok && CMP_IN.temp_high_ok) && !CMP_IN.temp_disable);

  // Saturating run lengths, so that a long hold stays counted.
  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      {bad_q, off_q, trk_q, tgt_q, sel_q} <= '0;
      sel_p_q <= 1'b0;
    end else begin
      bad_q   <= qual_bad ? inc(bad_q) : 8'h00;
      off_q   <= !CMP_IN.supply_ok ? inc(off_q) : 8'h00;
      trk_q   <= CMP_IN.above_trickle ? inc(trk_q) : 8'h00;
      tgt_q   <= CMP_IN.at_target ? inc(tgt_q) : 8'h00;
      sel_q   <= (VOLTAGE_SELECT_IN == sel_p_q) ? inc(sel_q) : 8'h00;
      sel_p_q <= VOLTAGE_SELECT_IN;
    end
  end

  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (!RESET_N_IN);

  qual_hold_a: assert property (
    bad_q >= 8'd6 |-> !DRIVE_OUT.charge_en) else $error("charge on");
  pd_late_a: assert property (
    $rose(POWER_DOWN_OUT) |-> off_q >= 8'd20) else $error("early drop");
  pd_on_a: assert property (
    off_q >= 8'd30 |-> POWER_DOWN_OUT && !DRIVE_OUT.charge_en)
    else $error("no power down");
  ind_on_a: assert property (
    DRIVE_OUT.charge_en && $past(DRIVE_OUT.charge_en)
    |-> CHARGE_INDICATOR_OE_OUT) else $error("charge lamp off");
  fault_excl_a: assert property (
    FAULT_INDICATOR_OE_OUT |-> !CHARGE_INDICATOR_OE_OUT)
    else $error("both lamps on");
  trk_exit_a: assert property (
    trk_q >= 8'd6 |-> !DRIVE_OUT.trickle) else $error("stuck trickle");
  cv_entry_a: assert property (
    tgt_q >= 8'd6 && DRIVE_OUT.charge_en |-> DRIVE_OUT.const_voltage)
    else $error("no constant voltage");
  vsel_a: assert property (
    sel_q >= 8'd8 && DRIVE_OUT.charge_en
    |-> DRIVE_OUT.target_42 == VOLTAGE_SELECT_IN) else $error("target");
endmodule : lcs_sequencer_props

bind lcs_sequencer lcs_sequencer_props lcs_sequencer_props_i (
  .CLOCK_IN, .RESET_N_IN, .CMP_IN, .VOLTAGE_SELECT_IN, .DRIVE_OUT,
  .CHARGE_INDICATOR_OE_OUT, .FAULT_INDICATOR_OE_OUT, .POWER_DOWN_OUT);

//--- test/lcs_cell_model.sv
`timescale 1ns/10ps
// Cell seen by the sequencer: voltage climbs while charge is on, and
// current tapers while voltage is held at the target.
module lcs_cell_model #(
  parameter int TRK_LVL = 40,
  parameter int TGT_LVL = 100,
  parameter int RST_LVL = 90,
  parameter int CV_LEN  = 200
) (
  // Clock and reset
  input  wire logic                clk_in,
  input  wire logic                rst_n_in,
  // Drive and bench controls
  input  wire lcs_pkg::lcs_drive_t drive_in,
  input  wire logic [3:0]          step_in,
  input  wire logic                stall_in,
  input  wire logic                drain_in,
  // Comparator levels
  output logic                     above_trickle_out,
  output logic                     at_target_out,
  output logic                     below_restart_out,
  output logic                     low_current_out
);
  logic [7:0] lvl_q, cv_q;
  logic [3:0] div_q;

  // A stalled cell neither gains voltage nor tapers, which is how the
  // bench provokes the safety timers; step_in sets a slow or fast cell.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lvl_q <= 8'h00;
      div_q <= 4'h0;
    end else if (drain_in) begin
      lvl_q <= (lvl_q == 8'h00) ? lvl_q : lvl_q - 8'h01;
    end else if (drive_in.charge_en && !stall_in) begin
      div_q <= (div_q >= step_in) ? 4'h0 : div_q + 4'h1;
      if (div_q >= step_in && lvl_q < 8'(TGT_LVL)) begin
        lvl_q <= lvl_q + 8'h01;
      end
    end
  end

  // A suspended cell relaxes, so the taper starts over.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cv_q <= 8'h00;
    end else if (drive_in.charge_en && drive_in.const_voltage && !stall_in)
    begin
      cv_q <= (cv_q == 8'hff) ? cv_q : cv_q + 8'h01;
    end else begin
      cv_q <= 8'h00;
    end
  end

  assign above_trickle_out = lvl_q >= 8'(TRK_LVL);
  assign at_target_out     = lvl_q >= 8'(TGT_LVL);
  assign below_restart_out = lvl_q < 8'(RST_LVL);
  assign low_current_out   = cv_q >= 8'(CV_LEN);
endmodule : lcs_cell_model

//--- test/tb.sv
`timescale 1ns/10ps
// Sequencer bench: register access, charge flow, holds and timeouts.
module tb;
  lcs_pkg::lcs_cmp_t   env, cmp;
  lcs_pkg::lcs_drive_t drv;
  logic        clk, rst_n, vsel, stall, drain, a_trk, a_tgt, b_rst, low_i;
  logic        awvalid, wvalid, bready, arvalid, rready, awready, wready;
  logic        bvalid, arready, rvalid, chg_oe, flt_oe, pd;
  logic        chg_o, flt_o;
  logic [3:0]  step, wstrb;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  int          fail_count, n_compared, n, t;

  always #25 clk = ~clk;

  // Cell levels come from the model, the rest from the bench.
  always_comb begin
    cmp = env;
    cmp.above_trickle = a_trk;
    cmp.at_target = a_tgt;
    cmp.below_restart = b_rst;
    cmp.below_term_current = low_i;
  end

  lcs_sequencer lcs_sequencer_i (
    .CLOCK_IN(clk), .RESET_N_IN(rst_n), .CMP_IN(cmp),
    .VOLTAGE_SELECT_IN(vsel), .AWADDR_IN(awaddr), .AWVALID_IN(awvalid),
    .AWREADY_OUT(awready), .WDATA_IN(wdata), .WSTRB_IN(wstrb),
    .WVALID_IN(wvalid), .WREADY_OUT(wready), .BRESP_OUT(bresp),
    .BVALID_OUT(bvalid), .BREADY_IN(bready), .ARADDR_IN(araddr),
    .ARVALID_IN(arvalid), .ARREADY_OUT(arready), .RDATA_OUT(rdata),
    .RRESP_OUT(rresp), .RVALID_OUT(rvalid), .RREADY_IN(rready),
    .DRIVE_OUT(drv), .CHARGE_INDICATOR_OUT(chg_o),
    .FAULT_INDICATOR_OUT(flt_o),
    .CHARGE_INDICATOR_OE_OUT(chg_oe), .FAULT_INDICATOR_OE_OUT(flt_oe),
    .POWER_DOWN_OUT(pd));

  lcs_cell_model lcs_cell_model_i (
    .clk_in(clk), .rst_n_in(rst_n), .drive_in(drv), .step_in(step),
    .stall_in(stall), .drain_in(drain), .above_trickle_out(a_trk),
    .at_target_out(a_tgt), .below_restart_out(b_rst),
    .low_current_out(low_i));

  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  task automatic wt(input int c);
    repeat (c) @(posedge clk);
  endtask : wt

  // Address and data go out together; each drops once it is taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input logic [3:0] s, input logic [1:0] er);
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    {awvalid, wvalid, bready} <= 3'b111;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk(32'(bresp), 32'(er));
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] e, input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk(rdata & m, e);
    chk(32'(rresp), 32'(er));
  endtask : rd

  // Counts level changes of one lamp over sixteen cycles.
  task automatic tog(input logic w, output int c);
    logic p, s;
    c = 0;
    p = w ? chg_oe : flt_oe;
    repeat (16) begin
      @(posedge clk);
      s = w ? chg_oe : flt_oe;
      if (s !== p) c++;
      p = s;
    end
  endtask : tog

  // Longest test path is about sixteen thousand cycles.
  initial begin
    wt(60000);
    fail_count++;
    finish_test();
  end

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    env = '0;
    {env.supply_ok, env.temp_low_ok, env.temp_high_ok} = 3'b111;
    env.die_cool = 1'b1;
    {vsel, stall, drain, step} = 7'b100_0010;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    fail_count = 0;
    n_compared = 0;
    wt(8);
    rst_n <= 1'b1;
    rd(lcs_pkg::CTRL_OFFSET, '1, lcs_pkg::CTRL_RESET, 2'b00);
    rd(lcs_pkg::TICK_OFFSET, '1, lcs_pkg::TICK_RESET, 2'b00);
    rd(lcs_pkg::THROT_OFFSET, 32'hf, 32'h2, 2'b00);
    rd(8'h10, '1, 32'h0, 2'b10);
    wr(8'h10, 32'h1, 4'hf, 2'b10);
    wr(lcs_pkg::STATUS_OFFSET, 32'h3f, 4'hf, 2'b00);
    rd(lcs_pkg::STATUS_OFFSET, 32'h3f, 32'h01, 2'b00);
    wr(lcs_pkg::TICK_OFFSET, 32'hffff_ff00, 4'h1, 2'b00);
    rd(lcs_pkg::TICK_OFFSET, '1, 32'h0, 2'b00);
    // Software sense disable must force the temperature valid.
    wr(lcs_pkg::CTRL_OFFSET, 32'h0, 4'h1, 2'b00);
    rd(lcs_pkg::CTRL_OFFSET, '1, 32'h0, 2'b00);
    env.temp_high_ok <= 1'b0;
    wt(4);
    rd(lcs_pkg::STATUS_OFFSET, 32'h7f, 32'h41, 2'b00);
    wr(lcs_pkg::CTRL_OFFSET, 32'h1, 4'h1, 2'b00);
    rd(lcs_pkg::STATUS_OFFSET, 32'h7f, 32'h01, 2'b00);
    env.temp_high_ok <= 1'b1;
    wt(4);
    $display("registers done");
    env.enable <= 1'b1;
    while (!(drv.charge_en && drv.trickle)) @(posedge clk);
    wt(2);
    chk(32'(chg_oe), 32'h1);
    while (!drv.const_voltage) @(posedge clk);
    wt(2);
    chk(32'(drv.target_42), 32'h1);
    env.temp_high_ok <= 1'b0;
    wt(8);
    chk(32'(drv.charge_en), 32'h0);
    rd(lcs_pkg::STATUS_OFFSET, 32'h3f, 32'h08, 2'b00);
    tog(1'b0, t);
    chk(32'(t >= 2), 32'h1);
    env.temp_high_ok <= 1'b1;
    wt(8);
    chk(32'(drv.charge_en), 32'h1);
    {env.temp_low_ok, env.temp_disable} <= 2'b01;
    wt(8);
    chk(32'(drv.charge_en), 32'h1);
    {env.temp_low_ok, env.temp_disable} <= 2'b10;
    {env.die_hot, env.die_cool} <= 2'b10;
    wt(8);
    chk(32'(drv.charge_en), 32'h0);
    env.die_hot <= 1'b0;
    wt(8);
    chk(32'(drv.charge_en), 32'h0);
    env.die_cool <= 1'b1;
    wt(8);
    chk(32'(drv.charge_en), 32'h1);
    while (drv.charge_en) @(posedge clk);
    wt(2);
    rd(lcs_pkg::STATUS_OFFSET, 32'h3f, 32'h10, 2'b00);
    tog(1'b1, t);
    chk(32'(t >= 2), 32'h1);
    $display("charge done");
    vsel <= 1'b0;
    drain <= 1'b1;
    wt(15);
    drain <= 1'b0;
    n = 0;
    while (!drv.charge_en) begin
      @(posedge clk);
      n++;
    end
    chk(32'(n <= 12), 32'h1);
    while (!drv.const_voltage) @(posedge clk);
    wt(2);
    chk(32'(drv.target_42), 32'h0);
    env.enable <= 1'b0;
    wt(8);
    rd(lcs_pkg::STATUS_OFFSET, 32'h3f, 32'h01, 2'b00);
    $display("recharge done");
    {stall, drain} <= 2'b11;
    wt(110);
    {drain, env.enable} <= 2'b01;
    while (!drv.trickle) @(posedge clk);
    n = 0;
    while (!flt_oe) begin
      @(posedge clk);
      n++;
    end
    chk(32'(n >= 3550 && n <= 3700), 32'h1);
    wt(20);
    rd(lcs_pkg::STATUS_OFFSET, 32'h3f, 32'h20, 2'b00);
    env.enable <= 1'b0;
    wt(8);
    rd(lcs_pkg::STATUS_OFFSET, 32'h3f, 32'h01, 2'b00);
    {stall, env.thermal_reg, env.enable} <= 3'b011;
    while (!(drv.charge_en && !drv.trickle && a_trk)) @(posedge clk);
    stall <= 1'b1;
    n = 0;
    while (!flt_oe) begin
      @(posedge clk);
      n++;
    end
    chk(32'(n >= 10700 && n <= 10950), 32'h1);
    {env.thermal_reg, env.enable} <= 2'b00;
    $display("timers done");
    env.supply_ok <= 1'b0;
    wt(10);
    env.supply_ok <= 1'b1;
    wt(30);
    chk(32'(pd), 32'h0);
    env.supply_ok <= 1'b0;
    wt(40);
    chk(32'(pd), 32'h1);
    env.supply_ok <= 1'b1;
    wt(30);
    chk(32'(pd), 32'h0);
    chk(32'({chg_o, flt_o}), 32'h0);
    $display("supply done");
    finish_test();
  end
endmodule : tb
